// [core/psdr_bank.sv]
// Read-only stage diagnostic register bank with live supply-present bit.
// Assumes the serial front end decodes read and clear instructions into
// one-cycle strobes on clk; fault codes arrive from detectors on clk.
// Function
// - Five read-only 8-bit registers, reset all-ones
// - Registers one-four pack four stages, two bits
// - Fifth register holds stages 17, 18 low
// - Codes: 11 ok, 10 short/hot, 01 open, 00 ground
// - Bit 4 of fifth shows battery present
// - Battery bit valid only with logic supply good
// - Battery bit live at read, never latched
// - Fifth register bits 7-5 read one
// - Each register read by its own instruction
// - Clear restores all-ones, live faults kept
`timescale 1ns/100ps
`default_nettype none

module psdr_bank (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [35:0]            stageFaultBits,
  input  wire logic                   batterySupplyPresent,
  input  wire logic                   logicSupplyOk,
  input  wire logic                   readDiagInstruction,
  input  wire logic [psdr_pkg::SEL_WIDTH-1:0] readSel,
  input  wire logic                   clearDiagInstruction,
  output logic [7:0]                  readData,
  output logic                        readValid,
  output logic                        supplyBitValid
);
  import psdr_pkg::*;

  // Two-flop synchronisers for the analogue comparator levels
  logic batSync1_q;
  logic batSync2_q;
  logic vddSync1_q;
  logic vddSync2_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      batSync1_q <= 1'b1;
      batSync2_q <= 1'b1;
      vddSync1_q <= 1'b0;
      vddSync2_q <= 1'b0;
    end else begin
      batSync1_q <= batterySupplyPresent;
      batSync2_q <= batSync1_q;
      vddSync1_q <= logicSupplyOk;
      vddSync2_q <= vddSync1_q;
    end
  end

  // Stored stage fields, one cell per power stage
  logic [CODE_WIDTH*STAGE_COUNT-1:0] stored;

  genvar g;
  generate
    for (g = 0; g < STAGE_COUNT; g++) begin : gStage
      psdr_stage_cell uCell (
        .clk        (clk),
        .rst        (rst),
        .faultCode  (stageFaultBits[CODE_WIDTH*g +: CODE_WIDTH]),
        .clearDiag  (clearDiagInstruction),
        .storedCode (stored[CODE_WIDTH*g +: CODE_WIDTH])
      );
    end
  endgenerate

  // Assemble one register image from stored fields and live supply bit
  function automatic logic [7:0] regImage(input logic [2:0] sel,
                                          input logic [35:0] fields,
                                          input logic bat);
    logic [7:0] img;
    img = REG_RESET;
    unique case (sel)
      SEL_GROUP_A: img = fields[7:0];
      SEL_GROUP_B: img = fields[15:8];
      SEL_GROUP_C: img = fields[23:16];
      SEL_GROUP_D: img = fields[31:24];
      SEL_GROUP_E: img = {UNUSED_FILL, bat, fields[35:32]};
      default:     img = REG_RESET;
    endcase
    return img;
  endfunction

  // Read answer: captured on the instruction, supply bit sampled then
  psdr_state_t state_q;
  psdr_state_t state_d;
  logic [7:0]  data_q;
  logic [7:0]  data_d;
  logic        valid_q;
  logic        valid_d;
  logic        supOk_q;
  logic        supOk_d;

  always_comb begin
    state_d = state_q;
    data_d  = data_q;
    valid_d = 1'b0;
    supOk_d = vddSync2_q;
    unique case (state_q)
      PSDR_IDLE: begin
        if (readDiagInstruction) begin
          // Live comparator level, no hold between reads
          data_d  = regImage(readSel, stored, batSync2_q);
          valid_d = 1'b1;
          state_d = PSDR_HOLD;
        end
      end
      PSDR_HOLD: begin
        // One idle cycle keeps back-to-back strobes from merging
        state_d = PSDR_IDLE;
      end
      default: state_d = PSDR_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PSDR_IDLE;
      data_q  <= REG_RESET;
      valid_q <= 1'b0;
      supOk_q <= 1'b0;
    end else begin
      state_q <= state_d;
      data_q  <= data_d;
      valid_q <= valid_d;
      supOk_q <= supOk_d;
    end
  end

  assign readData       = data_q;
  assign readValid      = valid_q;
  assign supplyBitValid = supOk_q;

  // Checks
  a_fifth_fill: assert property (@(posedge clk) disable iff (rst)
    (readDiagInstruction && state_q == PSDR_IDLE && readSel == SEL_GROUP_E)
      |=> (readData[7:5] == 3'h7 && readValid))
    else $error("fifth register unused bits not high");

  a_read_answer: assert property (@(posedge clk) disable iff (rst)
    (readDiagInstruction && state_q == PSDR_IDLE) |=> readValid ##1 !readValid)
    else $error("read answer not a single pulse");

  a_bat_live: assert property (@(posedge clk) disable iff (rst)
    (readDiagInstruction && state_q == PSDR_IDLE && readSel == SEL_GROUP_E)
      |=> readData[SUPPLY_BIT] == $past(batSync2_q))
    else $error("battery bit not live");

  a_group_a: assert property (@(posedge clk) disable iff (rst)
    (readDiagInstruction && state_q == PSDR_IDLE && readSel == SEL_GROUP_A)
      |=> readData == $past(stored[7:0]))
    else $error("group a image wrong");

  a_group_e_low: assert property (@(posedge clk) disable iff (rst)
    (readDiagInstruction && state_q == PSDR_IDLE && readSel == SEL_GROUP_E)
      |=> readData[3:0] == $past(stored[35:32]))
    else $error("stages 17 18 misplaced");

  a_clear_ok: assert property (@(posedge clk) disable iff (rst)
    (clearDiagInstruction && stageFaultBits == {36{1'b1}})
      |=> stored == {36{1'b1}})
    else $error("clear did not restore all ones");

  a_fault_kept: assert property (@(posedge clk) disable iff (rst)
    (!clearDiagInstruction && stored[1:0] != CODE_HEALTHY)
      |=> $stable(stored[1:0]))
    else $error("stored fault lost without clear");

  a_supply_valid: assert property (@(posedge clk) disable iff (rst)
    !vddSync2_q |=> !supplyBitValid)
    else $error("supply bit flagged valid with low logic supply");

  a_fault_take: assert property (@(posedge clk) disable iff (rst)
    (stored[1:0] == CODE_HEALTHY && stageFaultBits[1:0] == CODE_SHORT_GND)
      |=> stored[1:0] == CODE_SHORT_GND)
    else $error("ground short not captured");

  // Remaining group images, one check per register
  // A swapped slice would show as a wrong byte here
  a_group_b: assert property (@(posedge clk) disable iff (rst)
    (readDiagInstruction && state_q == PSDR_IDLE && readSel == SEL_GROUP_B)
      |=> readData == $past(stored[15:8]))
    else $error("group b image wrong");

  // Third group image
  a_group_c: assert property (@(posedge clk) disable iff (rst)
    (readDiagInstruction && state_q == PSDR_IDLE && readSel == SEL_GROUP_C)
      |=> readData == $past(stored[23:16]))
    else $error("group c image wrong");

  // Fourth group image
  a_group_d: assert property (@(posedge clk) disable iff (rst)
    (readDiagInstruction && state_q == PSDR_IDLE && readSel == SEL_GROUP_D)
      |=> readData == $past(stored[31:24]))
    else $error("group d image wrong");

  // Fifth image as a whole: fill, live supply bit, last two stages
  a_group_e_full: assert property (@(posedge clk) disable iff (rst)
    (readDiagInstruction && state_q == PSDR_IDLE && readSel == SEL_GROUP_E)
      |=> readData == {UNUSED_FILL, $past(batSync2_q), $past(stored[35:32])})
    else $error("fifth register image wrong");

  // Unmapped selects answer with the reset image
  a_unmapped_sel: assert property (@(posedge clk) disable iff (rst)
    (readDiagInstruction && state_q == PSDR_IDLE && readSel > SEL_GROUP_E)
      |=> readData == REG_RESET)
    else $error("unmapped select not all ones");

  // Answer stands until the next taken read
  a_data_hold: assert property (@(posedge clk) disable iff (rst)
    !(readDiagInstruction && state_q == PSDR_IDLE) |=> $stable(readData))
    else $error("read data changed without a read");

  // No answer without a taken instruction
  a_valid_cause: assert property (@(posedge clk) disable iff (rst)
    !(readDiagInstruction && state_q == PSDR_IDLE) |=> !readValid)
    else $error("answer without a read");

  // Strobe after an answer is refused, so valid never doubles
  a_refused_read: assert property (@(posedge clk) disable iff (rst)
    readValid |=> !readValid)
    else $error("answer pulse longer than one cycle");

  // Only the two written-out state codes may appear
  a_state_legal: assert property (@(posedge clk) disable iff (rst)
    state_q == PSDR_IDLE || state_q == PSDR_HOLD)
    else $error("read state code illegal");

  // Hold lasts one cycle, so reads are locked out for that one cycle only
  a_hold_returns: assert property (@(posedge clk) disable iff (rst)
    state_q == PSDR_HOLD |=> state_q == PSDR_IDLE)
    else $error("read hold state stuck");

  // Valid flag follows the synchronised logic supply (vddSync2_q) one cycle later
  a_supply_follow: assert property (@(posedge clk) disable iff (rst)
    vddSync2_q |=> supplyBitValid)
    else $error("supply bit not flagged valid with good supply");

  // Battery level passes both flops in order
  a_bat_chain: assert property (@(posedge clk) disable iff (rst)
    batSync2_q == $past(batSync1_q))
    else $error("battery synchroniser out of order");

  // Logic supply level passes both flops in order
  a_vdd_chain: assert property (@(posedge clk) disable iff (rst)
    vddSync2_q == $past(vddSync1_q))
    else $error("supply synchroniser out of order");

  // Per-stage capture, hold and clear, one set per field
  // Stage one alone is covered above; this reaches all eighteen
  genvar c;
  generate
    for (c = 0; c < STAGE_COUNT; c++) begin : gCheck
      // Healthy field takes whatever code the detector shows
      a_stage_take: assert property (@(posedge clk) disable iff (rst)
        (!clearDiagInstruction
          && stored[CODE_WIDTH*c +: CODE_WIDTH] == CODE_HEALTHY)
          |=> stored[CODE_WIDTH*c +: CODE_WIDTH]
            == $past(stageFaultBits[CODE_WIDTH*c +: CODE_WIDTH]))
        else $error("healthy stage field missed a code");

      // Stored fault sits still until a clear
      a_stage_kept: assert property (@(posedge clk) disable iff (rst)
        (!clearDiagInstruction
          && stored[CODE_WIDTH*c +: CODE_WIDTH] != CODE_HEALTHY)
          |=> $stable(stored[CODE_WIDTH*c +: CODE_WIDTH]))
        else $error("stage fault lost without clear");

      // Clear leaves only what the detector still reports
      a_stage_clear: assert property (@(posedge clk) disable iff (rst)
        clearDiagInstruction
          |=> stored[CODE_WIDTH*c +: CODE_WIDTH]
            == $past(stageFaultBits[CODE_WIDTH*c +: CODE_WIDTH]))
        else $error("stage field wrong after clear");
    end
  endgenerate

endmodule

`default_nettype wire

// [inc/psdr_pkg.sv]
// Package of the stage-diagnostic register bank: widths, codes, selects.
// Shared by the bank and its stage field cell; no assumptions beyond SV.
package psdr_pkg;

  // Bank shape
  localparam int         STAGE_COUNT   = 18;
  localparam int         REG_COUNT     = 5;
  localparam int         REG_WIDTH     = 8;
  localparam int         CODE_WIDTH    = 2;
  localparam int         STAGES_PER_REG = 4;
  localparam int         SEL_WIDTH     = 3;

  // Reset value of every register
  localparam logic [7:0] REG_RESET     = 8'hff;

  // Stage fault codes, upper bit first
  localparam logic [1:0] CODE_HEALTHY  = 2'h3;
  localparam logic [1:0] CODE_SHORT_BAT = 2'h2;
  localparam logic [1:0] CODE_OPEN     = 2'h1;
  localparam logic [1:0] CODE_SHORT_GND = 2'h0;

  // Fifth register layout
  localparam int         SUPPLY_BIT    = 4;
  localparam logic [2:0] UNUSED_FILL   = 3'h7;

  // Register selects of the read instructions
  localparam logic [2:0] SEL_GROUP_A   = 3'h0;
  localparam logic [2:0] SEL_GROUP_B   = 3'h1;
  localparam logic [2:0] SEL_GROUP_C   = 3'h2;
  localparam logic [2:0] SEL_GROUP_D   = 3'h3;
  localparam logic [2:0] SEL_GROUP_E   = 3'h4;

  // Read handshake states
  typedef enum logic [1:0] {
    PSDR_IDLE = 2'b01,
    PSDR_HOLD = 2'b10
  } psdr_state_t;

endpackage

// [core/psdr_stage_cell.sv]
// One stored 2-bit stage fault field.
// Assumes the fault code input is already synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module psdr_stage_cell (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] faultCode,
  input  wire logic       clearDiag,
  output logic [1:0]      storedCode
);
  import psdr_pkg::*;

  logic [1:0] code_q;
  logic [1:0] code_d;

  // Healthy field takes a new fault; a live fault survives a clear
  always_comb begin
    code_d = code_q;
    if (clearDiag) begin
      code_d = faultCode;
    end else if (code_q == CODE_HEALTHY) begin
      code_d = faultCode;
    end
  end

  // Stored until cleared, even after the fault goes away
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_q <= CODE_HEALTHY;
    end else begin
      code_q <= code_d;
    end
  end

  assign storedCode = code_q;

endmodule

`default_nettype wire

// [verification/psdr_host_model.sv]
// Host model: serial master issuing read and clear strobes to the bank.
// Assumes the bank answers a taken read with readValid one edge later.
`timescale 1ns/100ps
`default_nettype none
module psdr_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] readData,
  input  wire logic       readValid,
  output logic            readDiagInstruction,
  output logic [2:0]      readSel,
  output logic            clearDiagInstruction
);
  initial begin
    readDiagInstruction = 1'b0;
    readSel = 3'h7;
    clearDiagInstruction = 1'b0;
  end
  // One strobe per register read; the select is scrambled while idle
  task automatic readReg(input logic [2:0] sel, output logic [7:0] data, output logic ok);
    @(posedge clk);
    #1;
    readDiagInstruction = 1'b1;
    readSel = sel;
    @(posedge clk);
    #1;
    readDiagInstruction = 1'b0;
    readSel = ~sel;
    ok = 1'b0;
    data = 8'h00;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (readValid === 1'b1) begin
        ok = 1'b1;
        data = readData;
      end else begin
        @(posedge clk);
        #1;
      end
    end
  endtask
  // Clear strobe, one cycle wide
  task automatic clearDiag();
    @(posedge clk);
    #1;
    clearDiagInstruction = 1'b1;
    @(posedge clk);
    #1;
    clearDiagInstruction = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verification/power_stage_diag_registers_tb.sv]
// Bench of the diagnostic bank: reset image, layout, capture, clear, supply.
// Assumes the host model performs every read and clear strobe.
`timescale 1ns/100ps
`default_nettype none
module power_stage_diag_registers_tb;
  import psdr_pkg::*;
  logic        clk, rst, batterySupplyPresent, logicSupplyOk, supplyBitValid;
  logic        readDiagInstruction, clearDiagInstruction, readValid;
  logic [35:0] stageFaultBits;
  logic [2:0]  readSel;
  logic [7:0]  readData, d;
  int          failures, comparisons;
  // Distinct byte per register so a swapped mapping shows
  localparam logic [35:0] PAT = 36'h4_1b_27_8d_e4;

  psdr_bank dut (.clk(clk), .rst(rst), .stageFaultBits(stageFaultBits),
    .batterySupplyPresent(batterySupplyPresent), .logicSupplyOk(logicSupplyOk),
    .readDiagInstruction(readDiagInstruction), .readSel(readSel),
    .clearDiagInstruction(clearDiagInstruction), .readData(readData),
    .readValid(readValid), .supplyBitValid(supplyBitValid));
  psdr_host_model host (.clk(clk), .readData(readData), .readValid(readValid),
    .readDiagInstruction(readDiagInstruction), .readSel(readSel),
    .clearDiagInstruction(clearDiagInstruction));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic conclude();
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Read through the host; a lost answer ends the run
  task automatic rdChk(input logic [2:0] sel, input logic [7:0] exp);
    logic ok;
    host.readReg(sel, d, ok);
    if (!ok) begin
      failures++;
      conclude();
    end
    chk("readData", d, exp);
  endtask
  task automatic testReset();
    for (int s = 0; s < 8; s++) rdChk(s[2:0], REG_RESET);
  endtask
  task automatic testLayout();
    stageFaultBits = PAT;
    tick(2);
    for (int s = 0; s < 4; s++) rdChk(s[2:0], PAT[8*s+:8]);
    rdChk(SEL_GROUP_E, 8'hf4);
  endtask
  // Faults stay after the cause goes; healthy fields still capture
  task automatic testHold();
    stageFaultBits = '1;
    tick(2);
    rdChk(SEL_GROUP_B, 8'h8d);
    stageFaultBits = '0;
    tick(2);
    rdChk(SEL_GROUP_A, 8'h24);
  endtask
  // Clear with stage 1 still open: that entry survives
  task automatic testClear();
    stageFaultBits = {34'h3_ffff_ffff, CODE_OPEN};
    host.clearDiag();
    rdChk(SEL_GROUP_A, 8'hfd);
    rdChk(SEL_GROUP_D, 8'hff);
    rdChk(SEL_GROUP_E, 8'hff);
  endtask
  task automatic testSupply();
    batterySupplyPresent = 1'b0;
    tick(4);
    rdChk(SEL_GROUP_E, 8'hef);
    batterySupplyPresent = 1'b1;
    tick(4);
    rdChk(SEL_GROUP_E, 8'hff);
    logicSupplyOk = 1'b0;
    tick(5);
    chk("supplyBitValid", {7'h0, supplyBitValid}, 8'h00);
    logicSupplyOk = 1'b1;
    tick(5);
    chk("supplyBitValid", {7'h0, supplyBitValid}, 8'h01);
  endtask
  initial begin
    failures = 0;
    comparisons = 0;
    rst = 1'b1;
    stageFaultBits = '1;
    batterySupplyPresent = 1'b1;
    logicSupplyOk = 1'b1;
    tick(10);
    rst = 1'b0;
    testReset();
    testLayout();
    testHold();
    testClear();
    testSupply();
    conclude();
  end
endmodule
`default_nettype wire
